// ==== logic/mia_arbiter.sv ====
// Eligibility check and highest-level pick among pending sources, lower index on a tie
`timescale 1ns/1ps
`include "mia_cfg.svh"
module mia_arbiter
  import mia_pkg::*;
(
  // Request state
  input  wire logic [`MIA_NUM_SRC-1:0]                 pend_i,
  input  wire logic [`MIA_NUM_SRC-1:0][`MIA_LVL_W-1:0] lvl_i,
  // Processor state
  input  wire logic                                    ien_i,
  input  wire logic [`MIA_LVL_W-1:0]                   ipl_i,
  // Winner
  output logic                                         any_o,
  output logic [`MIA_IDX_W-1:0]                        idx_o,
  output logic [`MIA_LVL_W-1:0]                        lvl_o
);

  logic [`MIA_NUM_SRC-1:0] elig;

  // Three-way acceptance test per source
  genvar g;
  generate
    for (g = 0; g < `MIA_NUM_SRC; g++) begin : g_elig
      // Level 0 never exceeds any processor level, so it stays off
      assign elig[g] = ien_i & pend_i[g] & (lvl_i[g] > ipl_i);
    end
  endgenerate

  // Highest level wins; on a tie the lower index wins
  always_comb begin
    any_o = 1'b0;
    idx_o = '0;
    lvl_o = '0;
    for (int i = `MIA_NUM_SRC - 1; i >= 0; i--) begin
      if (elig[i] && (lvl_i[i] >= lvl_o)) begin
        any_o = 1'b1;
        idx_o = i[`MIA_IDX_W-1:0];
        lvl_o = lvl_i[i];
      end
    end
  end

endmodule : mia_arbiter

// ==== logic/mia_cfg.svh ====
// Constants of the maskable interrupt acceptance block
`ifndef MIA_CFG_SVH
`define MIA_CFG_SVH

// Sources and field widths
`define MIA_NUM_SRC     8
`define MIA_IDX_W       3
`define MIA_LVL_W       3
`define MIA_NUM_W       6
// Interrupt number of source 0; arbitrary placement below 32
`define MIA_VEC_BASE    6'h08

// Flag register layout and reset value
`define MIA_FLAG_W      16
`define MIA_FLAG_RST    16'h0000
`define MIA_FLAG_D      2
`define MIA_FLAG_I      6
`define MIA_FLAG_U      7
`define MIA_FLAG_IPL_LO 12
`define MIA_FLAG_IPL_HI 14

// Software interrupt numbers that keep the stack select flag
`define MIA_SOFT_LO     6'h20
`define MIA_SOFT_HI     6'h3F

// Timing counts in clock cycles
`define MIA_WAIT_MAX    5'h1E
`define MIA_SEQ_EE      5'h12
`define MIA_SEQ_ONE_ODD 5'h13
`define MIA_SEQ_BOTH    5'h14
`define MIA_SEQ_BUS8    5'h14
`define MIA_ADD_DBG     5'h02
`define MIA_ADD_STEP    5'h01

`endif

// ==== logic/mia_pkg.sv ====
// Types of the maskable interrupt acceptance block
`include "mia_cfg.svh"
package mia_pkg;

  // Sequence steps
  typedef enum logic [2:0] {
    MIA_IDLE,
    MIA_ACK,
    MIA_SAVE,
    MIA_CLRF,
    MIA_PUSHF,
    MIA_PUSHPC,
    MIA_FILL,
    MIA_FIN
  } mia_state_t;

  // Kind of interrupt that lengthens the sequence
  typedef enum logic [1:0] {
    MIA_KIND_PLAIN,
    MIA_KIND_STEP,
    MIA_KIND_DBG
  } mia_kind_t;

endpackage : mia_pkg

// ==== logic/mia_seq_timer.sv ====
// Length of the interrupt sequence and a count down to its last cycle
`timescale 1ns/1ps
`include "mia_cfg.svh"
module mia_seq_timer
  import mia_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_i,
  input  wire logic      nrst_i,
  // Start and conditions sampled with it
  input  wire logic      start_i,
  input  wire logic      bus8_i,
  input  wire logic      vec_odd_i,
  input  wire logic      sp_odd_i,
  input  wire mia_kind_t kind_i,
  // Next cycle is the final one of the sequence
  output logic           near_end_o
);

  logic [4:0] base_len;
  logic [4:0] add_len;
  logic [4:0] seq_len;
  logic [4:0] cnt;

  // Base length from bus width and alignment
  assign base_len = bus8_i ? `MIA_SEQ_BUS8 :
                    (vec_odd_i & sp_odd_i) ? `MIA_SEQ_BOTH :
                    (vec_odd_i | sp_odd_i) ? `MIA_SEQ_ONE_ODD :
                    `MIA_SEQ_EE;
  assign add_len  = (kind_i == MIA_KIND_DBG)  ? `MIA_ADD_DBG :
                    (kind_i == MIA_KIND_STEP) ? `MIA_ADD_STEP :
                    5'h00;
  assign seq_len  = base_len + add_len;
  assign near_end_o = (cnt == 5'h02);

  // Cycles left in the sequence, counting the current one
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt <= 5'h00;
    end else if (start_i) begin
      cnt <= seq_len;
    end else if (cnt != 5'h00) begin
      cnt <= cnt - 5'h01;
    end
  end

endmodule : mia_seq_timer

// ==== logic/mia_top.sv ====
// Maskable interrupt acceptance: request bits, levels, arbitration, sequence
`timescale 1ns/1ps
`include "mia_cfg.svh"
module mia_top
  import mia_pkg::*;
(
  // Clock and reset
  input  wire logic                                    clk_i,
  input  wire logic                                    nrst_i,
  // Peripheral request pulses, one per source
  input  wire logic [`MIA_NUM_SRC-1:0]                 src_req_i,
  // Software write of one source control register
  input  wire logic                                    ctl_wr_i,
  input  wire logic [`MIA_IDX_W-1:0]                   ctl_sel_i,
  input  wire logic [`MIA_LVL_W-1:0]                   ctl_lvl_i,
  input  wire logic                                    ctl_req_i,
  // Software write of the flag register
  input  wire logic                                    flag_wr_i,
  input  wire logic [`MIA_FLAG_W-1:0]                  flag_i,
  // Instruction sequencer status
  input  wire logic                                    instr_done_i,
  input  wire logic                                    instr_susp_i,
  // Sequence length conditions
  input  wire logic                                    bus8_i,
  input  wire logic                                    vec_odd_i,
  input  wire logic                                    sp_odd_i,
  input  wire mia_kind_t                               kind_i,
  // Program counter to be stacked
  input  wire logic [19:0]                             pc_i,
  // Register state
  output logic [`MIA_NUM_SRC-1:0]                      pending_request_bit_o,
  output logic [`MIA_NUM_SRC-1:0][`MIA_LVL_W-1:0]      source_priority_field_o,
  output logic [`MIA_FLAG_W-1:0]                       cpu_flag_register_o,
  // Sequence to the instruction pipeline and stack
  output logic                                         seq_busy_o,
  output logic                                         ack_rd_o,
  output logic [`MIA_NUM_W-1:0]                        ack_num_o,
  output logic [`MIA_LVL_W-1:0]                        ack_lvl_o,
  output logic                                         push_flag_o,
  output logic                                         push_pc_o,
  output logic [19:0]                                  push_data_o,
  output logic                                         seq_done_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [`MIA_NUM_SRC-1:0]                 pend;
  logic [`MIA_NUM_SRC-1:0][`MIA_LVL_W-1:0] lvl;
  logic [`MIA_FLAG_W-1:0]                  flag;
  logic [`MIA_FLAG_W-1:0]                  temp_flag;
  mia_state_t                              state;
  mia_state_t                              next_state;
  logic [4:0]                              wait_cnt;
  logic [`MIA_IDX_W-1:0]                   win_idx;
  logic [`MIA_LVL_W-1:0]                   win_lvl;
  logic [`MIA_NUM_W-1:0]                   win_num;
  logic [19:0]                             pc_hold;

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic                    arb_any;
  logic [`MIA_IDX_W-1:0]   arb_idx;
  logic [`MIA_LVL_W-1:0]   arb_lvl;
  logic                    ien;
  logic [`MIA_LVL_W-1:0]   processor_priority_level;
  logic                    idle;
  logic                    wait_over;
  logic                    start;
  logic                    near_end;
  logic                    soft_num;
  logic [`MIA_NUM_SRC-1:0] sw_clr;
  logic [`MIA_NUM_SRC-1:0] hw_clr;
  logic [`MIA_NUM_SRC-1:0] ctl_hit;
  logic [`MIA_NUM_SRC-1:0] next_pend;
  logic [`MIA_FLAG_W-1:0]  cleared_flag;
  logic [`MIA_FLAG_W-1:0]  ipl_flag;

  // Enable flag and processor level sit in the flag register
  assign ien  = flag[`MIA_FLAG_I];
  assign processor_priority_level  = flag[`MIA_FLAG_IPL_HI:`MIA_FLAG_IPL_LO];
  assign idle = (state == MIA_IDLE);

  // Past the longest instruction the request is taken regardless
  assign wait_over = (wait_cnt >= `MIA_WAIT_MAX);

  // Arbitrate when the instruction ends or a long one can be cut
  assign start = idle & arb_any &
                 (instr_done_i | instr_susp_i | wait_over);

  // Stack select survives only for software numbers 32 to 63
  assign soft_num = (win_num >= `MIA_SOFT_LO) &
                    (win_num <= `MIA_SOFT_HI);

  // Flag copy with enable, debug and stack select cleared
  always_comb begin
    cleared_flag = flag;
    cleared_flag[`MIA_FLAG_I] = 1'b0;
    cleared_flag[`MIA_FLAG_D] = 1'b0;
    if (!soft_num) begin
      cleared_flag[`MIA_FLAG_U] = 1'b0;
    end
  end

  // Flag copy carrying the accepted level as processor level
  always_comb begin
    ipl_flag = flag;
    ipl_flag[`MIA_FLAG_IPL_HI:`MIA_FLAG_IPL_LO] = win_lvl;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pending bits: set by source, cleared by software 0 or acceptance

  genvar g;
  generate
    for (g = 0; g < `MIA_NUM_SRC; g++) begin : g_src
      assign ctl_hit[g] = ctl_wr_i & (ctl_sel_i == `MIA_IDX_W'(g));
      // Only a written 0 acts; a written 1 is ignored
      assign sw_clr[g]  = ctl_hit[g] & ~ctl_req_i;
      // Cleared only once the acknowledge read is done
      assign hw_clr[g]  = (state == MIA_ACK) &
                          (win_idx == `MIA_IDX_W'(g));
      // Sources share the core clock, so requests need no synchroniser
      // A request in the clearing cycle wins, so none is lost
      assign next_pend[g] = src_req_i[g] |
                            (pend[g] & ~sw_clr[g] & ~hw_clr[g]);

      // Level field touched only by its own control write
      always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
          lvl[g] <= '0;
        end else if (ctl_hit[g]) begin
          lvl[g] <= ctl_lvl_i;
        end
      end
    end
  endgenerate

  // Pending register update
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pend <= '0;
    end else begin
      pend <= next_pend;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration

  mia_arbiter u_arb (
    .pend_i (pend),
    .lvl_i  (lvl),
    .ien_i  (ien),
    .ipl_i  (processor_priority_level),
    .any_o  (arb_any),
    .idx_o  (arb_idx),
    .lvl_o  (arb_lvl)
  );

  // Instruction wait counter, only while a request is waiting
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      wait_cnt <= 5'h00;
    end else if (!idle || !arb_any) begin
      wait_cnt <= 5'h00;
    end else if (!wait_over) begin
      wait_cnt <= wait_cnt + 5'h01;
    end
  end

  // Winner is frozen for the whole sequence
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      win_idx <= '0;
      win_lvl <= '0;
      win_num <= '0;
      pc_hold <= '0;
    end else if (start) begin
      win_idx <= arb_idx;
      win_lvl <= arb_lvl;
      win_num <= `MIA_VEC_BASE + {3'h0, arb_idx};
      pc_hold <= pc_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence length

  mia_seq_timer u_tmr (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .start_i    (start),
    .bus8_i     (bus8_i),
    .vec_odd_i  (vec_odd_i),
    .sp_odd_i   (sp_odd_i),
    .kind_i     (kind_i),
    .near_end_o (near_end)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequence steps

  // One step per cycle, then filler until the timed length ends
  always_comb begin
    next_state = state;
    unique case (state)
      MIA_IDLE:   if (start) next_state = MIA_ACK;
      MIA_ACK:    next_state = MIA_SAVE;
      MIA_SAVE:   next_state = MIA_CLRF;
      MIA_CLRF:   next_state = MIA_PUSHF;
      MIA_PUSHF:  next_state = MIA_PUSHPC;
      MIA_PUSHPC: next_state = MIA_FILL;
      MIA_FILL:   if (near_end) next_state = MIA_FIN;
      MIA_FIN:    next_state = MIA_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state <= MIA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Saved flag copy, taken before any flag is cleared
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      temp_flag <= `MIA_FLAG_RST;
    end else if (state == MIA_SAVE) begin
      temp_flag <= flag;
    end
  end

  // Flag register; the sequence owns it while running, so a software
  // write then is dropped rather than racing the hardware update
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      flag <= `MIA_FLAG_RST;
    end else if (state == MIA_CLRF) begin
      flag <= cleared_flag;
    end else if (state == MIA_FIN) begin
      flag <= ipl_flag;
    end else if (idle && flag_wr_i) begin
      flag <= flag_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      seq_busy_o  <= 1'b0;
      ack_rd_o    <= 1'b0;
      push_flag_o <= 1'b0;
      push_pc_o   <= 1'b0;
      seq_done_o  <= 1'b0;
    end else begin
      seq_busy_o  <= (next_state != MIA_IDLE);
      ack_rd_o    <= (next_state == MIA_ACK);
      push_flag_o <= (next_state == MIA_PUSHF);
      push_pc_o   <= (next_state == MIA_PUSHPC);
      seq_done_o  <= (next_state == MIA_FIN);
    end
  end

  // Acknowledge data and stacked words
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ack_num_o   <= '0;
      ack_lvl_o   <= '0;
      push_data_o <= '0;
    end else begin
      if (start) begin
        ack_num_o <= `MIA_VEC_BASE + {3'h0, arb_idx};
        ack_lvl_o <= arb_lvl;
      end
      if (next_state == MIA_PUSHF) begin
        push_data_o <= {4'h0, temp_flag};
      end else if (next_state == MIA_PUSHPC) begin
        push_data_o <= pc_hold;
      end
    end
  end

  // State mirrors
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pending_request_bit_o   <= '0;
      source_priority_field_o <= '0;
      cpu_flag_register_o     <= `MIA_FLAG_RST;
    end else begin
      pending_request_bit_o   <= pend;
      source_priority_field_o <= lvl;
      cpu_flag_register_o     <= flag;
    end
  end

endmodule : mia_top

// ==== test/maskable_interrupt_acceptance_tb_top.sv ====
// Bench for the maskable interrupt acceptance block
`timescale 1ns/1ps
`include "mia_cfg.svh"
module maskable_interrupt_acceptance_tb_top
  import mia_pkg::*;
;
  logic clk_i, nrst_i, ctl_wr, ctl_req, flag_wr, susp, instr_done, instr_susp;
  logic bus8, vec_odd, sp_odd, seq_busy_o, ack_rd_o, push_flag_o, push_pc_o;
  logic             seq_done_o;
  logic [7:0]       raise, src_req, pending_request_bit_o;
  logic [2:0]       ctl_sel, ctl_lvl, gap, ack_lvl_o, s, l;
  logic [7:0][2:0]  source_priority_field_o;
  logic [15:0]      flag_v, cpu_flag_register_o;
  logic [5:0]       ack_num_o;
  logic [19:0]      pc, push_data_o;
  mia_kind_t        kind;
  logic [49:0]      exp_q[$];
  int               n_mismatch = 0;
  int               n_tests = 0;

  mia_src_model u_mia_src_model (.clk_i(clk_i), .nrst_i(nrst_i),
    .raise_i(raise), .gap_i(gap), .susp_i(susp), .src_req_o(src_req),
    .instr_done_o(instr_done), .instr_susp_o(instr_susp));
  mia_top u_mia_top (.clk_i(clk_i), .nrst_i(nrst_i), .src_req_i(src_req),
    .ctl_wr_i(ctl_wr), .ctl_sel_i(ctl_sel), .ctl_lvl_i(ctl_lvl),
    .ctl_req_i(ctl_req), .flag_wr_i(flag_wr), .flag_i(flag_v),
    .instr_done_i(instr_done), .instr_susp_i(instr_susp), .bus8_i(bus8),
    .vec_odd_i(vec_odd), .sp_odd_i(sp_odd), .kind_i(kind), .pc_i(pc),
    .pending_request_bit_o(pending_request_bit_o),
    .source_priority_field_o(source_priority_field_o),
    .cpu_flag_register_o(cpu_flag_register_o), .seq_busy_o(seq_busy_o),
    .ack_rd_o(ack_rd_o), .ack_num_o(ack_num_o), .ack_lvl_o(ack_lvl_o),
    .push_flag_o(push_flag_o), .push_pc_o(push_pc_o),
    .push_data_o(push_data_o), .seq_done_o(seq_done_o));

  ////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input string what, input logic [19:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : results

  // Control write; ctl_req of 1 must leave the pending bit alone
  task automatic ctl(input logic [2:0] sel, lvl, input logic req);
    @(posedge clk_i);
    ctl_wr  <= 1'b1;
    ctl_sel <= sel;
    ctl_lvl <= lvl;
    ctl_req <= req;
    @(posedge clk_i);
    ctl_wr  <= 1'b0;
  endtask : ctl

  task automatic wflag(input logic [15:0] v);
    @(posedge clk_i);
    flag_wr <= 1'b1;
    flag_v  <= v;
    @(posedge clk_i);
    flag_wr <= 1'b0;
  endtask : wflag

  task automatic fire(input logic [7:0] m);
    @(posedge clk_i);
    raise <= m;
    @(posedge clk_i);
    raise <= 8'h00;
  endtask : fire

  // Note the expected sequence from the length conditions now applied
  task automatic expect_seq(input logic [2:0] sel, lvl, input logic [15:0] f);
    logic [4:0] len;
    len = bus8 ? 5'h14 : 5'h12 + {4'h0, vec_odd} + {4'h0, sp_odd};
    len = len + ((kind == MIA_KIND_DBG) ? 5'h02 :
                 (kind == MIA_KIND_STEP) ? 5'h01 : 5'h00);
    exp_q.push_back({6'h08 + {3'h0, sel}, lvl, len, pc, f});
  endtask : expect_seq

  // Bounded wait until every noted sequence has run out
  task automatic settle();
    int k;
    k = 0;
    @(negedge clk_i);
    while ((seq_busy_o !== 1'b0 || exp_q.size() != 0) && k < 200) begin
      @(negedge clk_i);
      k++;
    end
    repeat (3) @(negedge clk_i);
    // A note still queued means a request was never taken
    check("notes left", 20'(exp_q.size()), 20'h0);
    exp_q.delete();
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  // Clock and watchdog; a hang counts as a mismatch
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    #80000;
    n_mismatch++;
    results();
  end

  // Watcher: any acknowledge takes the oldest note, an unexpected one fails
  initial begin : watch
    logic [49:0] e;
    int          n;
    forever begin
      @(negedge clk_i);
      if (ack_rd_o === 1'b1) begin
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 50'h0;
        check("ack number", ack_num_o, e[49:44]);
        check("ack level", ack_lvl_o, e[43:41]);
        n = 1;
        while (seq_done_o !== 1'b1 && n < 40) begin
          @(negedge clk_i);
          n++;
          if (push_flag_o === 1'b1)
            check("flag push", push_data_o, e[15:0]);
          if (push_pc_o === 1'b1)
            check("pc push", push_data_o, e[35:16]);
        end
        check("sequence length", 20'(n), {15'h0, e[40:36]});
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {nrst_i, ctl_wr, ctl_req, flag_wr, susp, bus8, vec_odd, sp_odd} = 8'h00;
    {raise, ctl_sel, ctl_lvl, gap, flag_v, pc} = 53'h0;
    kind = MIA_KIND_PLAIN;
    void'($urandom(32'h3028345E));
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(negedge clk_i);
    check("flag after reset", cpu_flag_register_o, 20'h0);
    $display("test reset done");
    // Equal levels pick the lower index; the other waits for a higher level
    @(posedge clk_i);
    pc <= 20'($urandom);
    ctl(3'h3, 3'h4, 1'b0);
    ctl(3'h5, 3'h4, 1'b0);
    wflag(16'h0040);
    @(negedge clk_i);
    expect_seq(3'h3, 3'h4, 16'h0040);
    fire(8'h28);
    settle();
    check("pending after ack", pending_request_bit_o, 20'h00020);
    wflag(16'h4040);
    repeat (40) @(negedge clk_i);
    check("busy at equal level", seq_busy_o, 20'h0);
    expect_seq(3'h5, 3'h5, 16'h4040);
    ctl(3'h5, 3'h5, 1'b1);
    settle();
    $display("test priority done");
    // Disabled: request is held, writing 1 is ignored, writing 0 clears
    wflag(16'h0000);
    ctl(3'h2, 3'h7, 1'b1);
    repeat (2) @(negedge clk_i);
    check("pending after write 1", pending_request_bit_o[2], 20'h0);
    fire(8'h04);
    repeat (40) @(negedge clk_i);
    check("pending while off", pending_request_bit_o[2], 20'h1);
    check("level kept", source_priority_field_o[2], 20'h7);
    check("flag kept", cpu_flag_register_o, 20'h0);
    ctl(3'h2, 3'h7, 1'b0);
    repeat (2) @(negedge clk_i);
    check("pending after write 0", pending_request_bit_o[2], 20'h0);
    $display("test masking done");
    // Every length condition and kind, random source, level and pacing
    for (int i = 0; i < 24; i++) begin
      @(posedge clk_i);
      {bus8, vec_odd, sp_odd} <= i[2:0];
      kind <= mia_kind_t'(i / 8);
      pc   <= 20'($urandom);
      gap  <= 3'($urandom);
      susp <= ($urandom % 4) == 0;
      s = 3'($urandom);
      l = 3'h1 + 3'($urandom % 7);
      // Debug and stack select set too, so their clearing is visible
      wflag(16'h00C4);
      ctl(s, l, 1'b0);
      @(negedge clk_i);
      expect_seq(s, l, 16'h00C4);
      fire(8'h01 << s);
      settle();
    end
    $display("test lengths done");
    results();
  end
endmodule : maskable_interrupt_acceptance_tb_top

bind mia_top mia_top_props u_mia_top_props (.clk_i(clk_i), .nrst_i(nrst_i),
  .src_req_i(src_req_i), .pending_request_bit_o(pending_request_bit_o),
  .cpu_flag_register_o(cpu_flag_register_o), .seq_busy_o(seq_busy_o),
  .ack_rd_o(ack_rd_o), .ack_num_o(ack_num_o), .ack_lvl_o(ack_lvl_o),
  .push_flag_o(push_flag_o), .push_pc_o(push_pc_o),
  .seq_done_o(seq_done_o));

// ==== test/mia_src_model.sv ====
// Peripheral sources and instruction sequencer facing the block
`timescale 1ns/1ps
module mia_src_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       nrst_i,
  // Commands from the bench
  input  wire logic [7:0] raise_i,
  input  wire logic [2:0] gap_i,
  input  wire logic       susp_i,
  // Toward the block
  output logic      [7:0] src_req_o,
  output logic            instr_done_o,
  output logic            instr_susp_o
);
  logic [2:0] cnt;

  ////////////////////////////////////////////////////////////////////////////
  // Raises become one-cycle pulses; quiet in reset so nothing arrives early
  always_ff @(posedge clk_i) begin
    src_req_o    <= nrst_i ? raise_i : 8'h00;
    cnt          <= (!nrst_i || cnt >= gap_i) ? 3'h0 : cnt + 3'h1;
    instr_done_o <= nrst_i && cnt >= gap_i;
  end

  // Long instruction running, so the block may break into it
  assign instr_susp_o = susp_i;
endmodule : mia_src_model

// ==== test/mia_top_props.sv ====
// Concurrent checks on the ports of the acceptance block
`timescale 1ns/1ps
`include "mia_cfg.svh"
module mia_top_props
  import mia_pkg::*;
(
  // Clock and reset
  input wire logic                    clk_i,
  input wire logic                    nrst_i,
  // Watched ports
  input wire logic [`MIA_NUM_SRC-1:0] src_req_i,
  input wire logic [`MIA_NUM_SRC-1:0] pending_request_bit_o,
  input wire logic [`MIA_FLAG_W-1:0]  cpu_flag_register_o,
  input wire logic                    seq_busy_o,
  input wire logic                    ack_rd_o,
  input wire logic [`MIA_NUM_W-1:0]   ack_num_o,
  input wire logic [`MIA_LVL_W-1:0]   ack_lvl_o,
  input wire logic                    push_flag_o,
  input wire logic                    push_pc_o,
  input wire logic                    seq_done_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  ////////////////////////////////////////////////////////////////////////////
  // Mirror outputs lag their registers by one cycle and the figures on them include it; sequence outputs match the state
  a_start_with_ack: assert property ($rose(seq_busy_o) |-> ack_rd_o)
    else $error("sequence began without acknowledge read");
  a_accept_cond: assert property ($rose(seq_busy_o) |->
    cpu_flag_register_o[6] && ack_lvl_o > cpu_flag_register_o[14:12])
    else $error("request taken while not eligible");
  a_push_flag_slot: assert property (ack_rd_o |-> ##3 push_flag_o)
    else $error("flag push not in fourth sequence cycle");
  a_pc_after_flag: assert property (push_flag_o |=> push_pc_o)
    else $error("pc push does not follow flag push");
  a_pend_cleared: assert property ((ack_rd_o && src_req_i == 8'h00) ##1
    (src_req_i == 8'h00) |=> !pending_request_bit_o[$past(ack_num_o[2:0], 2)])
    else $error("accepted request bit not cleared");
  a_flags_cleared: assert property (push_flag_o |=>
    !cpu_flag_register_o[6] && !cpu_flag_register_o[2] &&
    !cpu_flag_register_o[7])
    else $error("enable, debug or stack select flag not cleared");
  a_done_frees: assert property (seq_done_o |=> !seq_busy_o)
    else $error("busy outlasts the final sequence cycle");
  a_level_loaded: assert property (seq_done_o |=> ##1
    cpu_flag_register_o[14:12] == $past(ack_lvl_o, 2))
    else $error("processor level not loaded with accepted level");
  a_seq_length: assert property ($rose(seq_busy_o) |->
    ##[17:21] seq_done_o)
    else $error("sequence length outside its range");
  a_pend_set: assert property (|src_req_i |=> ##1
    (pending_request_bit_o & $past(src_req_i, 2)) == $past(src_req_i, 2))
    else $error("request did not set its pending bit");
endmodule : mia_top_props
